/* File: shared/cth_pkg.sv */
// Constants and carrier types for the cam track hysteresis stage.
// Assumes one 10 MHz clock and a 32-bit APB register bus.
package cth_pkg;
   localparam int CTH_TRACKS = 8;
   localparam int CTH_POS_W = 32;
   localparam int CTH_HYST_W = 16;
   localparam int CTH_WIDE_W = 34;
   // Hysteresis unit in position increments
   localparam logic [CTH_WIDE_W-1:0] CTH_HYST_UNIT = 34'h0_0000_0064;
   // Operating modes
   localparam logic [1:0] CTH_MODE_ABS = 2'h0;
   localparam logic [1:0] CTH_MODE_INC = 2'h1;
   localparam logic [1:0] CTH_MODE_TIME = 2'h2;
   // Register byte offsets
   localparam logic [7:0] CTH_REG_CTRL = 8'h00;
   localparam logic [7:0] CTH_REG_MODULO = 8'h04;
   localparam logic [7:0] CTH_REG_STATUS = 8'h08;
   localparam logic [7:0] CTH_REG_POSITION = 8'h0C;
   localparam logic [7:0] CTH_REG_HYST_BASE = 8'h20;
   localparam logic [7:0] CTH_REG_CAM_BASE = 8'h40;
   localparam logic [7:0] CTH_REG_CAM_END = 8'h80;
   // Field positions
   localparam int CTH_CTRL_MODE_LSB = 0;
   localparam int CTH_CTRL_EN_BIT = 8;
   localparam int CTH_MODULO_W = 30;
   localparam int CTH_STATUS_DIR_LSB = 8;
   // Reset values
   localparam logic [1:0] CTH_MODE_RST = 2'h0;
   localparam logic CTH_EN_RST = 1'b0;
   localparam logic [CTH_MODULO_W-1:0] CTH_MODULO_RST = 30'h0000_0000;
   localparam logic [CTH_HYST_W-1:0] CTH_HYST_RST = 16'h0000;
   localparam logic [CTH_POS_W-1:0] CTH_CAM_RST = 32'h0000_0000;

   typedef enum logic [1:0] {
      CTH_DIR_POS = 2'b01,
      CTH_DIR_NEG = 2'b10
   } cth_dir_t;

   typedef struct packed {
      logic [CTH_POS_W-1:0] on_pos;
      logic [CTH_POS_W-1:0] off_pos;
      logic [CTH_HYST_W-1:0] hyst;
   } cth_track_cfg_t;

   typedef struct packed {
      logic tick;
      logic first;
      logic [CTH_POS_W-1:0] pos;
      logic [CTH_POS_W-1:0] last_pos;
   } cth_sample_t;
endpackage

/* File: design/cth_top.sv */
// Cam track hysteresis stage: eight tracks, APB register file, position sampling.
// Assumes pos_in is a signed encoder position and cycle_tick a one-cycle call pulse,
// both synchronous to sys_clk.
//
// How it works
// - Per-track hysteresis, zero disables it
// - Hysteresis distance is setting times hundred
// - Positive approach: one from on point
// - Positive: hold one down to on minus H
// - Positive: zero at or beyond off point
// - Positive: reversing holds zero to off minus H
// - Positive: release point reached switches to negative
// - Negative approach: one below off point
// - Negative: hold one below off plus H
// - Negative: zero below on point
// - Negative: reversing holds zero below on plus H
// - Negative: release point passed switches to positive
// - Switch needs overrun by H, or H+1
// - Incremental and time modes wrap at modulo
// - Without hysteresis on sets, off clears
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.

////////////////////////////////////////////////////////////////////////////////
module cth_track
   import cth_pkg::*;
(
   input wire logic sys_clk,
   input wire logic reset,
   input wire cth_sample_t sample,
   input wire cth_track_cfg_t cfg,
   output logic track_out,
   output logic dir_neg
);
   cth_dir_t dir;
   cth_dir_t next_dir;
   logic next_out;
   logic signed [CTH_WIDE_W-1:0] x;
   logic signed [CTH_WIDE_W-1:0] last_x;
   logic signed [CTH_WIDE_W-1:0] on_x;
   logic signed [CTH_WIDE_W-1:0] off_x;
   logic signed [CTH_WIDE_W-1:0] h;
   logic up;
   logic plain;

   always_comb
   begin
      x = CTH_WIDE_W'($signed(sample.pos));
      last_x = CTH_WIDE_W'($signed(sample.last_pos));
      on_x = CTH_WIDE_W'($signed(cfg.on_pos));
      off_x = CTH_WIDE_W'($signed(cfg.off_pos));
      h = $signed(CTH_WIDE_W'(cfg.hyst) * CTH_HYST_UNIT);
      up = x > last_x;
      plain = (x >= on_x) && (x < off_x);
   end

   always_comb
   begin
      next_out = track_out;
      next_dir = dir;
      if (cfg.on_pos == cfg.off_pos)
      begin
         // Equal edges make the cam inactive
         next_out = 1'b0;
      end
      else if (sample.first)
      begin
         next_out = plain;
         next_dir = CTH_DIR_POS;
      end
      else if (cfg.hyst == CTH_HYST_RST)
      begin
         next_out = plain;
      end
      else if (dir == CTH_DIR_POS)
      begin
         if (x >= off_x)
         begin
            next_out = 1'b0;
            if (x >= off_x + h)
            begin
               next_dir = CTH_DIR_NEG;
            end
         end
         else if (x >= on_x)
         begin
            // Coming back from the off zone keeps zero until off minus H
            if ((x >= off_x - h) && !up)
            begin
               next_out = track_out;
            end
            else
            begin
               next_out = 1'b1;
            end
         end
         else if (x >= on_x - h)
         begin
            next_out = track_out;
         end
         else
         begin
            next_out = 1'b0;
         end
      end
      else
      begin
         if (x < on_x)
         begin
            next_out = 1'b0;
            if (x < on_x - h)
            begin
               next_dir = CTH_DIR_POS;
            end
         end
         else if (x < off_x)
         begin
            // Going forward from below the on point keeps zero until on plus H
            if ((x < on_x + h) && up)
            begin
               next_out = track_out;
            end
            else
            begin
               next_out = 1'b1;
            end
         end
         else if (x < off_x + h)
         begin
            next_out = track_out;
         end
         else
         begin
            next_out = 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         dir <= CTH_DIR_POS;
      end
      else if (sample.tick)
      begin
         dir <= next_dir;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         track_out <= 1'b0;
      end
      else if (sample.tick)
      begin
         track_out <= next_out;
      end
   end

   assign dir_neg = (dir == CTH_DIR_NEG);
endmodule
////////////////////////////////////////////////////////////////////////////////
module cth_top
   import cth_pkg::*;
(
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [CTH_POS_W-1:0] pos_in,
   input wire logic cycle_tick,
   output logic [CTH_TRACKS-1:0] track_out
);
   logic [1:0] operating_mode_select;
   logic enable;
   logic [CTH_MODULO_W-1:0] modulo;
   logic [CTH_HYST_W-1:0] hyst [CTH_TRACKS];
   logic [CTH_POS_W-1:0] cam_on [CTH_TRACKS];
   logic [CTH_POS_W-1:0] cam_off [CTH_TRACKS];
   logic [CTH_POS_W-1:0] last_pos;
   logic first;
   logic [CTH_POS_W-1:0] eval_pos;
   logic tick;
   logic [CTH_TRACKS-1:0] dir_neg;
   logic setup;
   logic wr_en;
   logic [31:0] next_rdata;
   logic next_err;
   logic [2:0] idx;
   ////////////////////////////////////////////////////////////////////////////
   // Position sampling and modulo wrap
   always_comb
   begin
      eval_pos = pos_in;
      if ((operating_mode_select != CTH_MODE_ABS) && (modulo != CTH_MODULO_RST)
         && (pos_in >= CTH_POS_W'(modulo)))
      begin
         eval_pos = pos_in - CTH_POS_W'(modulo);
      end
   end

   assign tick = cycle_tick && enable;

   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         last_pos <= CTH_CAM_RST;
         first <= 1'b1;
      end
      else if (tick)
      begin
         last_pos <= eval_pos;
         first <= 1'b0;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Tracks
   for (genvar g = 0; g < CTH_TRACKS; g++)
   begin : gen_track
      cth_track u_track (
         .sys_clk(sys_clk),
         .reset(reset),
         .sample('{tick: tick, first: first, pos: eval_pos, last_pos: last_pos}),
         .cfg('{on_pos: cam_on[g], off_pos: cam_off[g], hyst: hyst[g]}),
         .track_out(track_out[g]),
         .dir_neg(dir_neg[g])
      );
   end
   ////////////////////////////////////////////////////////////////////////////
   // APB slave: setup cycle latches the answer, access cycle completes
   assign setup = psel && !penable;
   assign wr_en = psel && penable && pready && pwrite && !pslverr;
   assign idx = paddr[4:2];

   always_comb
   begin
      next_rdata = 32'h0000_0000;
      next_err = 1'b0;
      if (paddr[1:0] != 2'h0)
      begin
         next_err = 1'b1;
      end
      else if (paddr == CTH_REG_CTRL)
      begin
         next_rdata[CTH_CTRL_MODE_LSB +: 2] = operating_mode_select;
         next_rdata[CTH_CTRL_EN_BIT] = enable;
      end
      else if (paddr == CTH_REG_MODULO)
      begin
         next_rdata[CTH_MODULO_W-1:0] = modulo;
      end
      else if (paddr == CTH_REG_STATUS)
      begin
         next_rdata[CTH_TRACKS-1:0] = track_out;
         next_rdata[CTH_STATUS_DIR_LSB +: CTH_TRACKS] = dir_neg;
      end
      else if (paddr == CTH_REG_POSITION)
      begin
         next_rdata = last_pos;
      end
      else if ((paddr >= CTH_REG_HYST_BASE) && (paddr < CTH_REG_CAM_BASE))
      begin
         next_rdata[CTH_HYST_W-1:0] = hyst[idx];
      end
      else if ((paddr >= CTH_REG_CAM_BASE) && (paddr < CTH_REG_CAM_END))
      begin
         next_rdata = paddr[2] ? cam_off[paddr[5:3]] : cam_on[paddr[5:3]];
      end
      else
      begin
         next_err = 1'b1;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end
      else
      begin
         pready <= setup;
         pslverr <= setup && next_err;
         if (setup && !pwrite)
         begin
            prdata <= next_rdata;
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Control registers
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         operating_mode_select <= CTH_MODE_RST;
         enable <= CTH_EN_RST;
         modulo <= CTH_MODULO_RST;
      end
      else if (wr_en && paddr == CTH_REG_CTRL)
      begin
         operating_mode_select <= pwdata[CTH_CTRL_MODE_LSB +: 2];
         enable <= pwdata[CTH_CTRL_EN_BIT];
      end
      else if (wr_en && paddr == CTH_REG_MODULO)
      begin
         modulo <= pwdata[CTH_MODULO_W-1:0];
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Per-track settings
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         for (int i = 0; i < CTH_TRACKS; i++)
         begin
            hyst[i] <= CTH_HYST_RST;
         end
      end
      else if (wr_en && paddr[7:5] == CTH_REG_HYST_BASE[7:5])
      begin
         hyst[idx] <= pwdata[CTH_HYST_W-1:0];
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         for (int i = 0; i < CTH_TRACKS; i++)
         begin
            cam_on[i] <= CTH_CAM_RST;
            cam_off[i] <= CTH_CAM_RST;
         end
      end
      else if (wr_en && paddr[7:6] == CTH_REG_CAM_BASE[7:6])
      begin
         if (paddr[2])
         begin
            cam_off[paddr[5:3]] <= pwdata;
         end
         else
         begin
            cam_on[paddr[5:3]] <= pwdata;
         end
      end
   end
endmodule

/* File: verif/cth_encoder.sv */
// Position feedback source: the drive encoder seen by the hysteresis stage.
// Assumes the bench requests each new position one cycle before its tick.
module cth_encoder
(
   input wire logic sys_clk,
   input wire logic load,
   input wire logic [31:0] target,
   output logic [31:0] position
);
   timeunit 1ns;
   timeprecision 1ns;
   always_ff @(posedge sys_clk)
      if (load)
         position <= target;
endmodule

/* File: verif/cth_chk.sv */
// Port checker for cth_top; mirrors register writes to judge track outputs.
// Assumes the master holds paddr through the access cycle.
module cth_chk
   import cth_pkg::*;
(
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [CTH_POS_W-1:0] pos_in,
   input wire logic cycle_tick,
   input wire logic [CTH_TRACKS-1:0] track_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic en;
   logic abs_mode;
   logic [CTH_POS_W-1:0] on_r [CTH_TRACKS];
   logic [CTH_POS_W-1:0] off_r [CTH_TRACKS];
   logic [CTH_HYST_W-1:0] h_r [CTH_TRACKS];
   logic [CTH_TRACKS-1:0] must0;
   logic [CTH_TRACKS-1:0] must1;
   logic signed [CTH_WIDE_W-1:0] x, lo, hi, hw;
   ////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge sys_clk)
      if (reset)
      begin
         en <= 1'b0;
         abs_mode <= 1'b1;
         for (int i = 0; i < CTH_TRACKS; i++)
         begin
            on_r[i] <= '0;
            off_r[i] <= '0;
            h_r[i] <= '0;
         end
      end
      else if (psel && penable && pready && pwrite && !pslverr)
      begin
         if (paddr == CTH_REG_CTRL)
         begin
            en <= pwdata[CTH_CTRL_EN_BIT];
            abs_mode <= pwdata[1:0] == CTH_MODE_ABS;
         end
         if (paddr[7:5] == 3'h1)
            h_r[paddr[4:2]] <= pwdata[CTH_HYST_W-1:0];
         if (paddr[7:6] == 2'h1 && !paddr[2])
            on_r[paddr[5:3]] <= pwdata;
         if (paddr[7:6] == 2'h1 && paddr[2])
            off_r[paddr[5:3]] <= pwdata;
      end
   // Regions where the output is fixed whatever the approach state
   always_comb
   begin
      x = {{2{pos_in[31]}}, pos_in};
      for (int i = 0; i < CTH_TRACKS; i++)
      begin
         hw = {18'h0_0000, h_r[i]} * CTH_HYST_UNIT;
         lo = {{2{on_r[i][31]}}, on_r[i]};
         hi = {{2{off_r[i][31]}}, off_r[i]};
         must0[i] = x < lo - hw || x >= hi + hw;
         must1[i] = x >= lo + hw && x < hi - hw;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (reset);
   a_track_low: assert property (
      $past(cycle_tick && en && abs_mode && !reset) |-> (track_out & $past(must0)) == '0)
      else $error("track on where it must be off");
   a_track_high: assert property (
      $past(cycle_tick && en && abs_mode && !reset) |-> (~track_out & $past(must1)) == '0)
      else $error("track off where it must be on");
   a_out_holds: assert property (!$past(cycle_tick && en) |-> $stable(track_out))
      else $error("track output moved without an enabled tick");
   a_ready_follow: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   a_ready_cause: assert property (pready |-> $past(psel && !penable))
      else $error("ready without setup");
   a_err_exact: assert property (
      pready |-> pslverr == (paddr[7] || paddr[7:4] == 4'h1 || paddr[1:0] != 2'h0))
      else $error("error flag wrong for address");
   a_status_mirror: assert property (
      pready && !pwrite && paddr == CTH_REG_STATUS |-> prdata[7:0] == $past(track_out))
      else $error("status does not show track outputs");
   c_err: cover property (pslverr);
   c_change: cover property ($past(cycle_tick) && track_out != $past(track_out));
   c_read: cover property (pready && !pwrite);
endmodule
bind cth_top cth_chk u_chk (.sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .pos_in(pos_in), .cycle_tick(cycle_tick), .track_out(track_out));

/* File: verif/cam_track_hysteresis_bench.sv */
// Self-checking bench for the cam track hysteresis stage.
// Assumes cth_top, cth_encoder and the bound checker are compiled alongside.
module cam_track_hysteresis_bench
   import cth_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, pos_in, on1, off1, p;
   logic pready, pslverr;
   logic cycle_tick = 1'b0;
   logic load = 1'b0;
   logic [31:0] target = 32'h0000_0000;
   logic [7:0] track_out;
   logic tick_q = 1'b0;
   logic [32:0] qr[$];
   logic [15:0] qt[$];
   logic [32:0] eb;
   logic [15:0] et;
   logic [31:0] rs = 32'h0000_A314;
   int n_errors = 0;
   int checks = 0;
   int hp[23] = '{0, 1000, 600, 500, 499, 3000, 5000, 5499, 4500, 4499, 5500, 4999, 5499,
      5500, 3000, 999, 1499, 1500, 999, 500, 1000, 499, 1000};
   bit hb[23] = '{0, 1, 1, 1, 0, 1, 0, 0, 0, 1, 0, 1, 1, 0, 1, 0, 0, 1, 0, 0, 0, 0, 1};
   always #50 sys_clk = ~sys_clk;
   cth_top u_dut (.sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pos_in(pos_in), .cycle_tick(cycle_tick), .track_out(track_out));
   cth_encoder u_enc (.sys_clk(sys_clk), .load(load), .target(target), .position(pos_in));
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] rnd();
      rs = rs ^ (rs << 13);
      rs = rs ^ (rs >> 17);
      rs = rs ^ (rs << 5);
      return rs;
   endfunction
   task automatic conclude();
      $display("checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
      input logic [32:0] e);
      int n;
      qr.push_back(e);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge sys_clk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1)
      begin
         n_errors++;
         conclude();
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic step(input logic [31:0] pos, input logic [7:0] m, input logic [7:0] e);
      qt.push_back({m, e});
      load <= 1'b1;
      target <= pos;
      @(posedge sys_clk);
      load <= 1'b0;
      cycle_tick <= 1'b1;
      @(posedge sys_clk);
      cycle_tick <= 1'b0;
      @(posedge sys_clk);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Scoreboard: oldest note against each bus answer and each tick result
   always @(posedge sys_clk)
      tick_q <= cycle_tick & ~reset;
   always @(negedge sys_clk)
   begin
      if (pready === 1'b1 && qr.size() > 0)
      begin
         eb = qr.pop_front();
         checks++;
         if (pslverr !== eb[32] || (!pwrite && prdata !== eb[31:0]))
         begin
            n_errors++;
            $display("BAD apb %h expected %h seen %h", paddr, eb, {pslverr, prdata});
         end
      end
      if (tick_q === 1'b1 && qt.size() > 0)
      begin
         et = qt.pop_front();
         checks++;
         if ((track_out & et[15:8]) !== et[7:0])
         begin
            n_errors++;
            $display("BAD track_out expected %h seen %h", et[7:0], track_out & et[15:8]);
         end
      end
   end
   initial
   begin
      repeat (100000) @(posedge sys_clk);
      n_errors++;
      conclude();
   end
   initial
   begin
      repeat (3) @(posedge sys_clk);
      reset <= 1'b0;
      @(posedge sys_clk);
      apb(1'b0, CTH_REG_STATUS, 32'h0, 33'h0);
      apb(1'b0, CTH_REG_HYST_BASE, 32'h0, 33'h0);
      apb(1'b0, 8'h10, 32'h0, {1'b1, 32'h0});
      apb(1'b0, 8'h80, 32'h0, {1'b1, 32'h0});
      apb(1'b1, CTH_REG_HYST_BASE, 32'h0000_0005, 33'h0);
      // Misaligned write must be refused and leave track 0 untouched
      apb(1'b1, 8'h21, 32'h0000_0007, {1'b1, 32'h0});
      apb(1'b0, CTH_REG_HYST_BASE, 32'h0, 33'h0_0000_0005);
      apb(1'b1, CTH_REG_CAM_BASE, 32'h0000_03E8, 33'h0);
      apb(1'b1, CTH_REG_CAM_BASE + 8'h04, 32'h0000_1388, 33'h0);
      apb(1'b1, CTH_REG_CAM_BASE + 8'h10, 32'h0000_03E8, 33'h0);
      apb(1'b1, CTH_REG_CAM_BASE + 8'h14, 32'h0000_07D0, 33'h0);
      apb(1'b1, CTH_REG_MODULO, 32'h0000_2710, 33'h0);
      apb(1'b1, CTH_REG_CTRL, 32'h0000_0100, 33'h0);
      $display("test registers done");
      for (int i = 0; i < 23; i++)
         step(hp[i], 8'h01, {7'h00, hb[i]});
      // Overrun to the release point: track 0 must report negative approach
      step(32'h0000_157C, 8'h01, 8'h00);
      apb(1'b0, CTH_REG_STATUS, 32'h0, 33'h0_0000_0100);
      $display("test hysteresis done");
      on1 = rnd() % 32'h0000_4E20;
      off1 = on1 + 32'h0000_0001 + rnd() % 32'h0000_4E20;
      apb(1'b1, CTH_REG_CAM_BASE + 8'h08, on1, 33'h0);
      apb(1'b1, CTH_REG_CAM_BASE + 8'h0C, off1, 33'h0);
      for (int i = 0; i < 16; i++)
      begin
         p = rnd() % 32'h0000_AFC8;
         step(p, 8'h02, {6'h00, p >= on1 && p < off1, 1'b0});
      end
      $display("test plain cams done");
      for (int m = 0; m < 3; m++)
      begin
         apb(1'b1, CTH_REG_CTRL, 32'h0000_0100 | m, 33'h0);
         step(32'h0000_2CEC, 8'h04, (m > 0) ? 8'h04 : 8'h00);
         apb(1'b0, CTH_REG_POSITION, 32'h0, (m > 0) ? 33'h0_0000_05DC : 33'h0_0000_2CEC);
      end
      $display("test modulo done");
      apb(1'b1, CTH_REG_CTRL, 32'h0000_0100, 33'h0);
      step(32'h0000_05DC, 8'h04, 8'h04);
      apb(1'b1, CTH_REG_CTRL, 32'h0000_0000, 33'h0);
      step(32'h0000_0000, 8'h04, 8'h04);
      apb(1'b0, CTH_REG_POSITION, 32'h0, 33'h0_0000_05DC);
      $display("test disable done");
      repeat (3) @(posedge sys_clk);
      conclude();
   end
endmodule
